// File: inc/rrex_pkg.sv
// rrex_pkg: constants and types for the return and rotate execution slice
// assumes a 14-bit instruction word and a 15-bit program counter
package rrex_pkg;
  localparam int INSN_W   = 14;
  localparam int PC_W     = 15;
  localparam int DATA_W   = 8;
  localparam int FADDR_W  = 7;
  // fixed encodings of the plain and interrupt return ops
  localparam logic [13:0] OPC_RET     = 14'h0008;
  localparam logic [13:0] OPC_IRQ_RET = 14'h0009;
  // 6-bit major opcodes in bits 13:8
  localparam logic [5:0]  MAJ_LIT_RET = 6'h34;
  localparam logic [5:0]  MAJ_ROT_L   = 6'h0D;
  localparam logic [5:0]  MAJ_ROT_R   = 6'h0C;
  localparam int DEST_BIT  = 7;
  localparam int GIE_BIT   = 7;
  localparam int RET_CYCLES = 2;
  localparam int ROT_CYCLES = 1;
  typedef enum logic [4:0] {
    RREX_OP_NONE = 5'h00,
    RREX_OP_IRET = 5'h01,
    RREX_OP_RET  = 5'h02,
    RREX_OP_LRET = 5'h04,
    RREX_OP_ROTL = 5'h08,
    RREX_OP_ROTR = 5'h10
  } rrex_op_t;
  typedef enum logic [1:0] {
    RREX_ST_IDLE = 2'h1,
    RREX_ST_FLUSH = 2'h2
  } rrex_state_t;
endpackage

// File: rtl/rrex_decode.sv
// rrex_decode: classifies an instruction word into one of the five ops, or RREX_OP_NONE if it matches none
// assumes a word from the same clock domain, purely combinational
`timescale 1ns/1ps
module rrex_decode (
  // instruction in
  input  wire logic [rrex_pkg::INSN_W-1:0] insn,
  // decoded op
  output rrex_pkg::rrex_op_t               op
);
  import rrex_pkg::*;
  wire logic [5:0] major;
  wire logic       is_iret;
  wire logic       is_ret;
  wire logic       is_lret;
  wire logic       is_rotl;
  wire logic       is_rotr;
  assign major   = insn[13:8];
  assign is_iret = (insn == OPC_IRQ_RET);
  assign is_ret  = (insn == OPC_RET);
  assign is_lret = (major == MAJ_LIT_RET);
  assign is_rotl = (major == MAJ_ROT_L);
  assign is_rotr = (major == MAJ_ROT_R);
  assign op = is_iret ? RREX_OP_IRET :
              is_ret  ? RREX_OP_RET  :
              is_lret ? RREX_OP_LRET :
              is_rotl ? RREX_OP_ROTL :
              is_rotr ? RREX_OP_ROTR : RREX_OP_NONE;
endmodule

// File: rtl/rrex_exec.sv
// rrex_exec: executes returns over two cycles and rotates through carry in one cycle
// assumes the core supplies stack top, file data and carry each cycle
//
// Functional notes
// - interrupt return pops the stack into the pc over two cycles, flags kept.
// - interrupt return also sets the global interrupt enable bit to one.
// - plain return pops the stack into the pc over two cycles, nothing else.
// - literal return loads its byte into the accumulator and pops into the pc.
// - rotate left shifts the file register left through carry in one cycle.
// - rotate right shifts the file register right through carry.
// - destination zero writes the accumulator, one writes the file register.
`timescale 1ns/1ps
module rrex_exec (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  // instruction issue
  input  wire logic                          insn_valid,
  input  wire logic [rrex_pkg::INSN_W-1:0]   insn,
  output logic                               insn_ready,
  // stack and file register inputs
  input  wire logic [rrex_pkg::PC_W-1:0]     stack_top,
  input  wire logic [rrex_pkg::DATA_W-1:0]   file_data,
  input  wire logic                          carry_in,
  // results
  output logic                               stack_pop,
  output logic                               pc_load,
  output logic [rrex_pkg::PC_W-1:0]          pc_value,
  output logic                               acc_we,
  output logic [rrex_pkg::DATA_W-1:0]        acc_data,
  output logic                               file_we,
  output logic [rrex_pkg::FADDR_W-1:0]       file_addr,
  output logic [rrex_pkg::DATA_W-1:0]        file_wdata,
  output logic                               carry_we,
  output logic                               carry_out,
  output logic                               global_irq_enable_set,
  // current file address for the read port
  output logic [rrex_pkg::FADDR_W-1:0]       file_raddr
);
  import rrex_pkg::*;

  logic                rst_meta;
  logic                rst_sync;
  rrex_state_t         state;
  rrex_state_t         next_state;
  rrex_op_t            op;
  wire logic           take;
  wire logic           is_return;
  wire logic           is_rotate;
  wire logic           dest_file;
  wire logic [7:0]     rot_result;
  wire logic           rot_carry;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  rrex_decode u_decode (
    .insn (insn),
    .op   (op)
  );

  // a return holds issue off for its second cycle
  assign insn_ready = (state == RREX_ST_IDLE);
  assign take       = insn_valid && insn_ready;
  assign is_return  = (op == RREX_OP_IRET) || (op == RREX_OP_RET) ||
                      (op == RREX_OP_LRET);
  assign is_rotate  = (op == RREX_OP_ROTL) || (op == RREX_OP_ROTR);
  assign dest_file  = insn[DEST_BIT];
  assign file_raddr = insn[FADDR_W-1:0];
  assign rot_result = (op == RREX_OP_ROTL) ?
                      {file_data[6:0], carry_in} :
                      {carry_in, file_data[7:1]};
  assign rot_carry  = (op == RREX_OP_ROTL) ? file_data[7] :
                      file_data[0];

  always_comb begin
    next_state = state;
    unique case (state)
      RREX_ST_IDLE:  if (take && is_return) next_state = RREX_ST_FLUSH;
      RREX_ST_FLUSH: next_state = RREX_ST_IDLE;
      default:       next_state = RREX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state <= RREX_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // result registers, enables pulse for one cycle per op, data values hold until rewritten
  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      stack_pop             <= 1'b0;
      pc_load               <= 1'b0;
      pc_value              <= '0;
      acc_we                <= 1'b0;
      acc_data              <= 8'h00;
      file_we               <= 1'b0;
      file_addr             <= 7'h00;
      file_wdata            <= 8'h00;
      carry_we              <= 1'b0;
      carry_out             <= 1'b0;
      global_irq_enable_set <= 1'b0;
    end else begin
      stack_pop             <= take && is_return;
      pc_load               <= take && is_return;
      if (take && is_return) begin
        pc_value <= stack_top;
      end
      global_irq_enable_set <= take && (op == RREX_OP_IRET);
      acc_we   <= take && ((op == RREX_OP_LRET) ||
                           (is_rotate && !dest_file));
      if (take && op == RREX_OP_LRET) begin
        acc_data <= insn[7:0];
      end else if (take && is_rotate) begin
        acc_data <= rot_result;
      end
      file_we  <= take && is_rotate && dest_file;
      if (take && is_rotate) begin
        file_addr  <= insn[FADDR_W-1:0];
        file_wdata <= rot_result;
        carry_out  <= rot_carry;
      end
      carry_we <= take && is_rotate;
    end
  end

  property p_ret_two_cycles;
    @(posedge clk) disable iff (!rst_sync)
      (take && is_return) |=> !insn_ready ##1 insn_ready;
  endproperty
  a_ret_two_cycles: assert property (p_ret_two_cycles)
    else $error("return did not take two cycles");

  property p_iret_gie;
    @(posedge clk) disable iff (!rst_sync)
      (take && op == RREX_OP_IRET) |=> global_irq_enable_set && pc_load;
  endproperty
  a_iret_gie: assert property (p_iret_gie)
    else $error("interrupt return did not set enable");

  property p_ret_plain;
    @(posedge clk) disable iff (!rst_sync)
      (take && op == RREX_OP_RET) |=> pc_load && !global_irq_enable_set
        && !acc_we && !carry_we;
  endproperty
  a_ret_plain: assert property (p_ret_plain)
    else $error("plain return touched other state");

  property p_lret_acc;
    @(posedge clk) disable iff (!rst_sync)
      (take && op == RREX_OP_LRET) |=>
        acc_we && acc_data == $past(insn[7:0]) && !carry_we;
  endproperty
  a_lret_acc: assert property (p_lret_acc)
    else $error("literal return lost its byte");

  property p_rotl;
    @(posedge clk) disable iff (!rst_sync)
      (take && op == RREX_OP_ROTL) |=> carry_we &&
        carry_out == $past(file_data[7]) && insn_ready;
  endproperty
  a_rotl: assert property (p_rotl)
    else $error("rotate left carry wrong");

  property p_rotr;
    @(posedge clk) disable iff (!rst_sync)
      (take && op == RREX_OP_ROTR) |=> carry_we &&
        carry_out == $past(file_data[0]) && !pc_load;
  endproperty
  a_rotr: assert property (p_rotr)
    else $error("rotate right carry wrong");

  property p_dest;
    @(posedge clk) disable iff (!rst_sync)
      (take && is_rotate) |=> (file_we != acc_we) &&
        (file_we == $past(dest_file));
  endproperty
  a_dest: assert property (p_dest)
    else $error("rotate destination wrong");

  property p_rot_bits;
    @(posedge clk) disable iff (!rst_sync)
      (take && op == RREX_OP_ROTL) |=>
        file_wdata == {$past(file_data[6:0]), $past(carry_in)};
  endproperty
  a_rot_bits: assert property (p_rot_bits)
    else $error("rotate left bits wrong");
endmodule

// File: verification/rrex_exec_bench.sv
// rrex_exec_bench: directed bench for the return and rotate slice
// assumes rrex_pkg is compiled first and rrex_exec checks itself
`timescale 1ns/1ps
module rrex_exec_bench;
  import rrex_pkg::*;
  logic                 clk;
  logic                 reset_n;
  logic                 insn_valid;
  logic [INSN_W-1:0]    insn;
  logic                 insn_ready;
  logic [PC_W-1:0]      stack_top;
  logic [DATA_W-1:0]    file_data;
  logic                 carry_in;
  logic                 stack_pop;
  logic                 pc_load;
  logic [PC_W-1:0]      pc_value;
  logic                 acc_we;
  logic [DATA_W-1:0]    acc_data;
  logic                 file_we;
  logic [FADDR_W-1:0]   file_addr;
  logic [DATA_W-1:0]    file_wdata;
  logic                 carry_we;
  logic                 carry_out;
  logic                 global_irq_enable_set;
  logic [FADDR_W-1:0]   file_raddr;
  int                   mismatches;
  int                   n_compared;

  rrex_exec i_dut (.clk(clk), .reset_n(reset_n), .insn_valid(insn_valid),
    .insn(insn), .insn_ready(insn_ready), .stack_top(stack_top),
    .file_data(file_data), .carry_in(carry_in), .stack_pop(stack_pop),
    .pc_load(pc_load), .pc_value(pc_value), .acc_we(acc_we),
    .acc_data(acc_data), .file_we(file_we), .file_addr(file_addr),
    .file_wdata(file_wdata), .carry_we(carry_we), .carry_out(carry_out),
    .global_irq_enable_set(global_irq_enable_set), .file_raddr(file_raddr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task close_out;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // holds the word until taken, returns just after the taking edge
  task issue(input logic [INSN_W-1:0] w);
    int n;
    n = 0;
    insn_valid = 1'b1;
    insn = w;
    while (insn_ready !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 8) begin
        mismatches++;
        close_out();
      end
    end
    @(posedge clk);
    #1;
  endtask

  // return taken, then a rotate offered in the refused cycle
  task t_ret(input logic [INSN_W-1:0] w, input logic [PC_W-1:0] top,
             input logic global_irq_enable, input logic lit, input logic [7:0] k);
    stack_top = top;
    issue(w);
    chk({stack_pop, pc_load, insn_ready}, 3'b110);
    chk(pc_value, top);
    chk(global_irq_enable_set, global_irq_enable);
    chk({carry_we, file_we}, 2'b00);
    chk(acc_we, lit);
    if (lit) chk(acc_data, k);
    stack_top = ~top;
    insn = {MAJ_ROT_L, 8'h85};
    @(posedge clk);
    #1;
    chk({stack_pop, pc_load, carry_we, insn_ready}, 4'b0001);
    chk(pc_value, top);
    insn_valid = 1'b0;
    @(posedge clk);
    #1;
    $display("return test %h done", w);
  endtask

  task t_rot(input logic left, input logic dest, input logic [6:0] a,
             input logic [7:0] d, input logic c);
    logic [7:0] r;
    logic       ec;
    r = left ? {d[6:0], c} : {c, d[7:1]};
    ec = left ? d[7] : d[0];
    file_data = d;
    carry_in = c;
    issue({left ? MAJ_ROT_L : MAJ_ROT_R, dest, a});
    chk(file_raddr, a);
    chk({carry_we, carry_out}, {1'b1, ec});
    chk({file_we, acc_we, stack_pop}, {dest, ~dest, 1'b0});
    if (dest) chk({file_addr, file_wdata}, {a, r});
    else chk(acc_data, r);
    $display("rotate test l%0d d%0d done", left, dest);
  endtask

  initial begin
    insn_valid = 1'b0;
    insn = '0;
    stack_top = '0;
    file_data = '0;
    carry_in = 1'b0;
    mismatches = 0;
    n_compared = 0;
    reset_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_ret(OPC_IRQ_RET, 15'h7FFF, 1'b1, 1'b0, 8'h00);
    t_ret(OPC_RET, 15'h0001, 1'b0, 1'b0, 8'h00);
    t_ret({MAJ_LIT_RET, 8'hFF}, 15'h2A55, 1'b0, 1'b1, 8'hFF);
    t_ret({MAJ_LIT_RET, 8'h00}, 15'h0000, 1'b0, 1'b1, 8'h00);
    t_rot(1'b1, 1'b0, 7'h7F, 8'hE6, 1'b0);
    for (int i = 0; i < 8; i++) begin
      t_rot(i[0], i[1], {7{i[2]}}, 8'hE6 ^ 8'(i * 37), i[2]);
    end
    issue(14'h0000);
    chk({stack_pop, pc_load, acc_we, file_we, carry_we}, 5'h00);
    chk(global_irq_enable_set, 1'b0);
    insn_valid = 1'b0;
    @(posedge clk);
    #1;
    close_out();
  end
endmodule
